//--- core/digital_input_conditioning_router.v
// Digital input conditioning: sampling, forcing, inversion, routing into
// a 32-bit input image, plus the output image, behind an AXI4-Lite slave.
// Assumes one clock (core_clk), a synchronous active-low reset and pins
// that are asynchronous to core_clk.
//
// Contract
// - Every input is sampled once per millisecond; shorter pulses may be missed.
// - Special-function, invert and force words act bitwise; a bit affects only its own input.
// - Special-function enable gates bits 0 to 15 only, never level bits.
// - Special bit 0 is negative limit, bit 1 positive limit, bit 2 home.
// - Home bit 2 defaults to absent input 3; routing must supply it.
// - Invert 0 gives normally open, invert 1 gives normally closed reading.
// - Inversion applies to ordinary and special inputs, not clock and direction.
// - A set force-enable bit replaces the sampled value with the force value.
// - The force-value word gives the value for each forced input.
// - The raw word shows sampled levels before forcing or inversion.
// - Threshold bit 0 is 5 V, 1 is 24 V; inputs 1 and 2 fixed 24 V.
// - Pair mode 0 single-ended ignores negative legs; 1 is differential.
// - Input 1 gives negative limit in image bit 0, its level in bit 16.
// - Writing 1 to map enable switches the input image to routing mode.
// - Enabling routing preloads the table so inputs behave as before.
// - Routing entry k+1 selects the source of input image bit k.
// - Codes: 00 zero, 01-10 inputs, 41-43 Hall, 44-46 encoder, 47 USB.
// - Adding 80 hex inverts a source; 80 gives constant one.
// - Output n is output image bit 15+n; bit 0 is the motor brake.
// - Each input owns a special bit and a level bit; outputs 1 to 4 own only a level bit (16 to 19).
`timescale 1ns/100ps
`include "dio_consts.vh"

module digital_input_conditioning_router
#(
  parameter SAMPLE_CYCLES = `DIO_SAMPLE_CYCLES  // Core clocks per sample
)
(
  input  wire        core_clk,      // System clock
  input  wire        nrst,          // Synchronous reset, active low
  input  wire        ce,            // Clock enable, freezes all state when low
  input  wire [7:0]  awaddr,        // Write address
  input  wire        awvalid,       // Write address valid
  output reg         awready,       // Write address ready
  input  wire [31:0] wdata,         // Write data
  input  wire [3:0]  wstrb,         // Write byte strobes
  input  wire        wvalid,        // Write data valid
  output reg         wready,        // Write data ready
  output reg  [1:0]  bresp,         // Write response
  output reg         bvalid,        // Write response valid
  input  wire        bready,        // Write response ready
  input  wire [7:0]  araddr,        // Read address
  input  wire        arvalid,       // Read address valid
  output reg         arready,       // Read address ready
  output reg  [31:0] rdata,         // Read data
  output reg  [1:0]  rresp,         // Read response
  output reg         rvalid,        // Read data valid
  input  wire        rready,        // Read data ready
  input  wire        limNegPin,     // Input 1 pin
  input  wire        limPosPin,     // Input 2 pin
  input  wire        enablePosPin,  // Input 4 positive leg
  input  wire        enableNegPin,  // Input 4 negative leg
  input  wire        dirPosPin,     // Input 5 positive leg
  input  wire        dirNegPin,     // Input 5 negative leg
  input  wire        clkPosPin,     // Input 6 positive leg
  input  wire        clkNegPin,     // Input 6 negative leg
  input  wire [2:0]  hallPin,       // Hall U, V, W
  input  wire [2:0]  encoderPin,    // Encoder A, B, index
  input  wire        usbPowerPin,   // USB power present
  output reg  [31:0] inputImage,    // Input image to the motion core
  output reg         brake,         // Motor brake output
  output reg  [3:0]  outLevel,      // Outputs 1 to 4
  output reg         threshold24v,  // Threshold of enable, direction, clock
  output reg         pairDiff       // Differential mode of the pairs
);

  localparam [`DIO_SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CYCLES - 1;

  // Write and read channel states.
  localparam [1:0] WS_COLLECT = 2'b01;
  localparam [1:0] WS_RESP    = 2'b10;
  localparam [1:0] RS_IDLE    = 2'b01;
  localparam [1:0] RS_DATA    = 2'b10;

  // Two-flop synchronisers for all pins.
  reg  [14:0] pinMeta_r;
  reg  [14:0] pinSync_r;
  wire [14:0] pinVec;

  reg  [`DIO_SAMPLE_CNT_W-1:0] sampleCnt_r;
  reg                          sampleStb_r;
  reg  [15:0]                  rawLevels_r;
  reg  [6:0]                   specLevels_r;

  reg  [31:0] sfMask_r;
  reg  [31:0] invert_r;
  reg  [31:0] forceMask_r;
  reg  [31:0] forceLevels_r;
  reg  [31:0] thresh_r;
  reg  [31:0] pairMode_r;
  reg  [31:0] mapEnable_r;
  reg  [31:0] outImage_r;
  reg  [7:0]  route_r [0:31];

  reg  [1:0]  wState_r;
  reg         awHave_r;
  reg         wHave_r;
  reg  [7:0]  wAddr_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg  [1:0]  rState_r;

  wire        wrFire;
  wire        wrHit;
  wire        preload;
  wire [15:0] pairLevel;
  wire [15:0] forced;
  wire [15:0] invEff;
  wire [15:0] levels;
  wire [31:0] normalImage;
  wire [31:0] routedImage;
  reg  [31:0] readWord;
  reg         readOk;

  assign pinVec = {usbPowerPin, encoderPin, hallPin, clkNegPin, clkPosPin,
                   dirNegPin, dirPosPin, enableNegPin, enablePosPin,
                   limPosPin, limNegPin};

  // Merges written bytes into an old register value.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // Picks one routing source and applies its inversion bit.
  function srcBit;
    input [7:0]  code;
    input [15:0] lv;
    input [6:0]  sp;
    reg          v;
    begin
      v = 1'b0;
      if (code[6:0] >= `DIO_SRC_PHYS_FIRST && code[6:0] <= `DIO_SRC_PHYS_LAST)
        v = lv[code[3:0] - 4'h1];
      else if (code[6:0] >= `DIO_SRC_SPEC_FIRST && code[6:0] <= `DIO_SRC_SPEC_LAST)
        v = sp[code[2:0] - 3'h1];
      srcBit = v ^ code[`DIO_SRC_INV_BIT];
    end
  endfunction

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pinMeta_r <= 15'h0000;
      pinSync_r <= 15'h0000;
    end
    else if (ce)
    begin
      pinMeta_r <= pinVec;
      pinSync_r <= pinMeta_r;
    end
  end

  // pair leg handling
  // Differential reads high when the positive leg is high and the negative low.
  assign pairLevel = {10'h000,
                      pinSync_r[6] & ~(pairMode_r[0] & pinSync_r[7]),
                      pinSync_r[4] & ~(pairMode_r[0] & pinSync_r[5]),
                      pinSync_r[2] & ~(pairMode_r[0] & pinSync_r[3]),
                      1'b0, pinSync_r[1], pinSync_r[0]};

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sampleCnt_r <= {`DIO_SAMPLE_CNT_W{1'b0}};
      sampleStb_r <= 1'b0;
    end
    else if (ce)
    begin
      sampleStb_r <= (sampleCnt_r == SAMPLE_LAST);
      if (sampleCnt_r == SAMPLE_LAST)
        sampleCnt_r <= {`DIO_SAMPLE_CNT_W{1'b0}};
      else
        sampleCnt_r <= sampleCnt_r + 1'b1;
    end
  end

  // sample once per ms
  // Absent input 3 and unused positions read as zero.
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rawLevels_r  <= 16'h0000;
      specLevels_r <= 7'h00;
    end
    else if (ce && sampleStb_r)
    begin
      rawLevels_r  <= pairLevel & `DIO_PRESENT_MASK;
      specLevels_r <= pinSync_r[14:8];
    end
  end

  assign forced = (rawLevels_r & ~forceMask_r[15:0]) | (forceLevels_r[15:0] & forceMask_r[15:0]);

  // no inversion on clock and direction
  assign invEff = invert_r[15:0] & ~`DIO_CLKDIR_MASK;

  assign levels = forced ^ invEff;

  // input 1 in bits 0 and 16
  // bit 0, 1, 2 limit and home
  // home bit from absent input 3
  assign normalImage = {levels, levels & sfMask_r[15:0]};

  assign preload = wrFire && (wAddr_r == `DIO_MAPEN_OFS) && wStrb_r[0] && wData_r[0]
                   && !mapEnable_r[0];

  genvar k;
  generate
    for (k = 0; k < 32; k = k + 1)
    begin : gRoute
      localparam [6:0] SRC_IDX = (k % 16) + 1;
      wire [7:0] seed;

      if (k < 16)
      begin : gSpecial
        assign seed = sfMask_r[k] ? {invEff[k], SRC_IDX} : `DIO_ROUTE_RST;
      end
      else
      begin : gLevel
        assign seed = {invEff[k-16], SRC_IDX};
      end

      always @(posedge core_clk)
      begin
        if (!nrst)
          route_r[k] <= `DIO_ROUTE_RST;
        else if (ce && preload)
          route_r[k] <= seed;
        else if (ce && wrFire && wAddr_r[`DIO_ROUTE_BIT] && wAddr_r[6:2] == k && wStrb_r[0])
          route_r[k] <= wData_r[7:0];
      end

      assign routedImage[k] = srcBit(route_r[k], forced, specLevels_r);
    end
  endgenerate

  always @(posedge core_clk)
  begin
    if (!nrst)
      inputImage <= 32'h00000000;
    else if (ce)
      inputImage <= mapEnable_r[0] ? routedImage : normalImage;
  end

  // Write channel: address and data are taken in either order.
  assign wrFire = wState_r[0] && awHave_r && wHave_r;
  assign wrHit  = wAddr_r[`DIO_ROUTE_BIT] || wAddr_r == `DIO_SFMASK_OFS
                  || wAddr_r == `DIO_INVERT_OFS || wAddr_r == `DIO_FMASK_OFS
                  || wAddr_r == `DIO_FLEVEL_OFS || wAddr_r == `DIO_THRESH_OFS
                  || wAddr_r == `DIO_PAIR_OFS || wAddr_r == `DIO_MAPEN_OFS
                  || wAddr_r == `DIO_OUTIMAGE_OFS;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wState_r <= WS_COLLECT;
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
      wAddr_r  <= 8'h00;
      wData_r  <= 32'h00000000;
      wStrb_r  <= 4'h0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `DIO_RESP_OKAY;
    end
    else if (ce)
    begin
      case (wState_r)
        WS_COLLECT:
        begin
          if (awvalid && awready)
          begin
            awHave_r <= 1'b1;
            awready  <= 1'b0;
            wAddr_r  <= {awaddr[7:2], 2'b00};
          end
          if (wvalid && wready)
          begin
            wHave_r <= 1'b1;
            wready  <= 1'b0;
            wData_r <= wdata;
            wStrb_r <= wstrb;
          end
          if (wrFire)
          begin
            awHave_r <= 1'b0;
            wHave_r  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= wrHit ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
            wState_r <= WS_RESP;
          end
        end
        WS_RESP:
        begin
          if (bready)
          begin
            bvalid   <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
            wState_r <= WS_COLLECT;
          end
        end
        default:
        begin
          wState_r <= WS_COLLECT;
        end
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sfMask_r      <= `DIO_SFMASK_RST;
      invert_r      <= `DIO_WORD_RST;
      forceMask_r   <= `DIO_WORD_RST;
      forceLevels_r <= `DIO_WORD_RST;
      thresh_r      <= `DIO_WORD_RST;
      pairMode_r    <= `DIO_WORD_RST;
      mapEnable_r   <= `DIO_WORD_RST;
      outImage_r    <= `DIO_WORD_RST;
    end
    else if (ce && wrFire)
    begin
      case (wAddr_r)
        `DIO_SFMASK_OFS:   sfMask_r      <= merge(sfMask_r, wData_r, wStrb_r);
        `DIO_INVERT_OFS:   invert_r      <= merge(invert_r, wData_r, wStrb_r);
        `DIO_FMASK_OFS:    forceMask_r   <= merge(forceMask_r, wData_r, wStrb_r);
        `DIO_FLEVEL_OFS:   forceLevels_r <= merge(forceLevels_r, wData_r, wStrb_r);
        `DIO_THRESH_OFS:   thresh_r      <= merge(thresh_r, wData_r, wStrb_r);
        `DIO_PAIR_OFS:     pairMode_r    <= merge(pairMode_r, wData_r, wStrb_r);
        `DIO_MAPEN_OFS:    mapEnable_r   <= merge(mapEnable_r, wData_r, wStrb_r);
        `DIO_OUTIMAGE_OFS: outImage_r    <= merge(outImage_r, wData_r, wStrb_r);
        default:           outImage_r    <= outImage_r;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      brake        <= 1'b0;
      outLevel     <= 4'h0;
      threshold24v <= 1'b0;
      pairDiff     <= 1'b0;
    end
    else if (ce)
    begin
      brake        <= outImage_r[0];
      outLevel     <= outImage_r[`DIO_OUT_LSB +: 4];
      threshold24v <= thresh_r[0];
      pairDiff     <= pairMode_r[0];
    end
  end

  always @*
  begin
    readWord = 32'h00000000;
    readOk   = 1'b1;
    if (araddr[`DIO_ROUTE_BIT])
      readWord = {24'h000000, route_r[araddr[6:2]]};
    else
    begin
      case ({araddr[7:2], 2'b00})
        `DIO_SFMASK_OFS:   readWord = sfMask_r;
        `DIO_INVERT_OFS:   readWord = invert_r;
        `DIO_FMASK_OFS:    readWord = forceMask_r;
        `DIO_FLEVEL_OFS:   readWord = forceLevels_r;
        `DIO_RAW_OFS:      readWord = {16'h0000, rawLevels_r};
        `DIO_THRESH_OFS:   readWord = thresh_r;
        `DIO_PAIR_OFS:     readWord = pairMode_r;
        `DIO_MAPEN_OFS:    readWord = mapEnable_r;
        `DIO_INIMAGE_OFS:  readWord = inputImage;
        `DIO_OUTIMAGE_OFS: readWord = outImage_r;
        default:           readOk   = 1'b0;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken.
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rState_r <= RS_IDLE;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h00000000;
      rresp    <= `DIO_RESP_OKAY;
    end
    else if (ce)
    begin
      case (rState_r)
        RS_IDLE:
        begin
          if (arvalid)
          begin
            arready  <= 1'b0;
            rvalid   <= 1'b1;
            rdata    <= readWord;
            rresp    <= readOk ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
            rState_r <= RS_DATA;
          end
        end
        RS_DATA:
        begin
          if (rready)
          begin
            rvalid   <= 1'b0;
            arready  <= 1'b1;
            rState_r <= RS_IDLE;
          end
        end
        default:
        begin
          rState_r <= RS_IDLE;
        end
      endcase
    end
  end

endmodule // digital_input_conditioning_router

//--- shared/dio_consts.vh
// Constants for the digital input conditioning router.
// Assumes a single 200 MHz clock and 32-bit AXI4-Lite register access.
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH

// Sampling time base.
`define DIO_CLK_MHZ          200
`define DIO_SAMPLE_PERIOD_US 1000
`define DIO_SAMPLE_CYCLES    (`DIO_CLK_MHZ * `DIO_SAMPLE_PERIOD_US)
`define DIO_SAMPLE_CNT_W     18

// Register byte offsets.
`define DIO_SFMASK_OFS    8'h00
`define DIO_INVERT_OFS    8'h04
`define DIO_FMASK_OFS     8'h08
`define DIO_FLEVEL_OFS    8'h0c
`define DIO_RAW_OFS       8'h10
`define DIO_THRESH_OFS    8'h14
`define DIO_PAIR_OFS      8'h18
`define DIO_MAPEN_OFS     8'h1c
`define DIO_INIMAGE_OFS   8'h20
`define DIO_OUTIMAGE_OFS  8'h24
`define DIO_ROUTE_BIT     7

// Reset values.
`define DIO_SFMASK_RST    32'h00000000
`define DIO_WORD_RST      32'h00000000
`define DIO_ROUTE_RST     8'h00

// Input layout: inputs 1,2,4,5,6 exist; 5 and 6 are direction and clock.
`define DIO_PRESENT_MASK  16'h003b
`define DIO_CLKDIR_MASK   16'h0030
`define DIO_LEVEL_LSB     16
`define DIO_OUT_LSB       16

// Routing source codes.
`define DIO_SRC_PHYS_FIRST 7'h01
`define DIO_SRC_PHYS_LAST  7'h10
`define DIO_SRC_SPEC_FIRST 7'h41
`define DIO_SRC_SPEC_LAST  7'h47
`define DIO_SRC_INV_BIT    7

// AXI responses.
`define DIO_RESP_OKAY     2'b00
`define DIO_RESP_SLVERR   2'b10

`endif

//--- tb/dio_checker.sv
// Concurrent checks on the bus handshakes and outputs of the input router.
// Assumes binding to the router's top module and no bus traffic while ce is low.
`timescale 1ns/100ps
module dio_checker
#(
  parameter SAMPLE_CYCLES = 8  // Core clocks per sample
)
(
  input wire        core_clk,      // Clock
  input wire        nrst,          // Reset, active low
  input wire        awvalid,       // Write address valid
  input wire        awready,       // Write address ready
  input wire        wvalid,        // Write data valid
  input wire        wready,        // Write data ready
  input wire [1:0]  bresp,         // Write response
  input wire        bvalid,        // Write response valid
  input wire        bready,        // Write response ready
  input wire        arvalid,       // Read address valid
  input wire        arready,       // Read address ready
  input wire [31:0] rdata,         // Read data
  input wire        rvalid,        // Read data valid
  input wire        rready,        // Read data ready
  input wire [31:0] inputImage,    // Input image
  input wire        brake,         // Brake output
  input wire [3:0]  outLevel,      // Outputs 1 to 4
  input wire        threshold24v,  // Threshold select
  input wire        pairDiff       // Pair mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_aw_busy: assert property (
    bvalid |-> !awready && !wready)
    else $error("write accepted while busy");
  a_read_answer: assert property (
    arvalid && arready |-> ##[1:2] rvalid)
    else $error("read data missing");
  a_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ar_busy: assert property (
    rvalid |-> !arready)
    else $error("read accepted while busy");
  a_reset_idle: assert property (disable iff (1'b0)
    !nrst |=> awready && arready && !bvalid && !rvalid && inputImage == 32'h0 && !brake)
    else $error("reset state wrong");
  a_out_by_write: assert property (
    $changed(brake) || $changed(outLevel) |-> bvalid || $past(bvalid))
    else $error("output changed without write");
  a_cfg_by_write: assert property (
    $changed(threshold24v) || $changed(pairDiff) |-> bvalid || $past(bvalid))
    else $error("pin mode changed without write");
endmodule // dio_checker

bind digital_input_conditioning_router dio_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (
  .core_clk(core_clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .inputImage(inputImage), .brake(brake), .outLevel(outLevel),
  .threshold24v(threshold24v), .pairDiff(pairDiff));

//--- tb/motion_io_partner.sv
// Far side: limit switches and a line driver for enable, direction and clock.
// Assumes the bench sets the wanted levels and holds each for a full sample.
`timescale 1ns/100ps
module motion_io_partner
(
  input  wire       negLimit,      // Negative limit switch closed
  input  wire       posLimit,      // Positive limit switch closed
  input  wire       enableLvl,     // Enable level
  input  wire       dirLvl,        // Direction level
  input  wire       stepLvl,       // Step clock level
  input  wire       negStuck,      // Negative legs held high
  input  wire [2:0] hallLvl,       // Hall U, V, W
  input  wire [2:0] encLvl,        // Encoder A, B, index
  input  wire       usbLvl,        // USB power present
  output wire       limNegPin,     // Input 1
  output wire       limPosPin,     // Input 2
  output wire       enablePosPin,  // Input 4 positive leg
  output wire       enableNegPin,  // Input 4 negative leg
  output wire       dirPosPin,     // Input 5 positive leg
  output wire       dirNegPin,     // Input 5 negative leg
  output wire       clkPosPin,     // Input 6 positive leg
  output wire       clkNegPin,     // Input 6 negative leg
  output wire [2:0] hallPin,       // Hall pins
  output wire [2:0] encoderPin,    // Encoder pins
  output wire       usbPowerPin    // USB power pin
);
  assign limNegPin = negLimit;
  assign limPosPin = posLimit;
  assign enablePosPin = enableLvl;
  assign dirPosPin = dirLvl;
  assign clkPosPin = stepLvl;
  // A healthy driver sends complements; a broken one leaves the negative legs high.
  assign enableNegPin = negStuck | ~enableLvl;
  assign dirNegPin = negStuck | ~dirLvl;
  assign clkNegPin = negStuck | ~stepLvl;
  assign hallPin = hallLvl;
  assign encoderPin = encLvl;
  assign usbPowerPin = usbLvl;
endmodule // motion_io_partner

//--- tb/test_digital_input_conditioning_router.sv
// Self-checking bench for the input router over AXI4-Lite.
// Assumes a sample period shortened to SC clocks.
`timescale 1ns/100ps
`include "dio_consts.vh"
module test_digital_input_conditioning_router;
  localparam SC = 8;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        negLimit = 1'b0, posLimit = 1'b0, enableLvl = 1'b0, dirLvl = 1'b0;
  logic        stepLvl = 1'b0, negStuck = 1'b0, usbLvl = 1'b0;
  logic [2:0]  hallLvl = 3'h0, encLvl = 3'h0;
  wire         awready, wready, bvalid, arready, rvalid, brake, threshold24v, pairDiff;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata, inputImage;
  wire [3:0]   outLevel;
  wire         limNegPin, limPosPin, enablePosPin, enableNegPin;
  wire         dirPosPin, dirNegPin, clkPosPin, clkNegPin, usbPowerPin;
  wire [2:0]   hallPin, encoderPin;
  int          n_errors = 0;
  int          checks = 0;
  logic [31:0] rd;
  logic [1:0]  rs;

  always #2.5 core_clk = ~core_clk;

  motion_io_partner far (.negLimit(negLimit), .posLimit(posLimit), .enableLvl(enableLvl),
    .dirLvl(dirLvl), .stepLvl(stepLvl), .negStuck(negStuck), .hallLvl(hallLvl),
    .encLvl(encLvl), .usbLvl(usbLvl), .limNegPin(limNegPin), .limPosPin(limPosPin),
    .enablePosPin(enablePosPin), .enableNegPin(enableNegPin), .dirPosPin(dirPosPin),
    .dirNegPin(dirNegPin), .clkPosPin(clkPosPin), .clkNegPin(clkNegPin),
    .hallPin(hallPin), .encoderPin(encoderPin), .usbPowerPin(usbPowerPin));

  digital_input_conditioning_router #(.SAMPLE_CYCLES(SC)) DUT (.core_clk(core_clk),
    .nrst(nrst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .limNegPin(limNegPin), .limPosPin(limPosPin), .enablePosPin(enablePosPin),
    .enableNegPin(enableNegPin), .dirPosPin(dirPosPin), .dirNegPin(dirNegPin),
    .clkPosPin(clkPosPin), .clkNegPin(clkNegPin), .hallPin(hallPin),
    .encoderPin(encoderPin), .usbPowerPin(usbPowerPin), .inputImage(inputImage),
    .brake(brake), .outLevel(outLevel), .threshold24v(threshold24v), .pairDiff(pairDiff));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid || !bvalid)
    begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (arvalid || !rvalid)
    begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Writes a register and expects it to be accepted.
  task automatic set(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk("write response", 32'(`DIO_RESP_OKAY), 32'(rs));
  endtask

  // Lets a pin change pass the synchronisers and one full sample.
  task automatic settle;
    repeat (4 * SC + 4) @(posedge core_clk);
  endtask

  task automatic look(input logic [31:0] raw, input logic [31:0] img);
    rdw(`DIO_RAW_OFS, rd, rs);
    chk("raw", raw, rd);
    rdw(`DIO_INIMAGE_OFS, rd, rs);
    chk("image register", img, rd);
    chk("image port", img, inputImage);
  endtask

  task automatic t_reset;
    for (int a = 0; a <= 8'h24; a += 4)
    begin
      rdw(8'(a), rd, rs);
      chk("reset value", 32'h0, rd);
    end
    rdw(8'h40, rd, rs);
    chk("unmapped read", 32'(`DIO_RESP_SLVERR), 32'(rs));
    wr(`DIO_RAW_OFS, 32'h1, rs);
    chk("raw write", 32'(`DIO_RESP_SLVERR), 32'(rs));
    wr(`DIO_INIMAGE_OFS, 32'h1, rs);
    chk("image write", 32'(`DIO_RESP_SLVERR), 32'(rs));
  endtask

  task automatic t_levels;
    negLimit <= 1'b1;
    dirLvl <= 1'b1;
    hallLvl <= 3'b001;
    encLvl <= 3'b010;
    usbLvl <= 1'b1;
    settle();
    look(32'h11, 32'h0011_0000);
    // Home bit stays off since the mask 3 leaves bit 2 clear.
    set(`DIO_SFMASK_OFS, 32'h3);
    look(32'h11, 32'h0011_0001);
  endtask

  task automatic t_invert;
    set(`DIO_INVERT_OFS, 32'h31);
    look(32'h11, 32'h0010_0000);
    set(`DIO_INVERT_OFS, 32'h2);
    look(32'h11, 32'h0013_0003);
    set(`DIO_INVERT_OFS, 32'h0);
  endtask

  task automatic t_force;
    set(`DIO_FMASK_OFS, 32'h3);
    set(`DIO_FLEVEL_OFS, 32'h2);
    look(32'h11, 32'h0012_0002);
    set(`DIO_FMASK_OFS, 32'h0);
    look(32'h11, 32'h0011_0001);
  endtask

  task automatic t_pairs;
    set(`DIO_THRESH_OFS, 32'h1);
    set(`DIO_PAIR_OFS, 32'h1);
    @(posedge core_clk);
    chk("threshold", 32'h1, 32'(threshold24v));
    chk("pair mode", 32'h1, 32'(pairDiff));
    negStuck <= 1'b1;
    settle();
    look(32'h01, 32'h0001_0001);
    set(`DIO_PAIR_OFS, 32'h0);
    settle();
    look(32'h11, 32'h0011_0001);
    negStuck <= 1'b0;
    settle();
  endtask

  // Clock enable low must hold every stage, so a pin change stays unseen.
  task automatic t_freeze;
    ce <= 1'b0;
    negLimit <= 1'b0;
    settle();
    chk("frozen image", 32'h0011_0001, inputImage);
    ce <= 1'b1;
    settle();
    chk("thawed image", 32'h0010_0000, inputImage);
    negLimit <= 1'b1;
    settle();
  endtask

  task automatic t_outputs;
    set(`DIO_OUTIMAGE_OFS, 32'h0005_0001);
    repeat (2) @(posedge core_clk);
    chk("brake", 32'h1, 32'(brake));
    chk("outputs", 32'h5, 32'(outLevel));
    rdw(`DIO_OUTIMAGE_OFS, rd, rs);
    chk("output image", 32'h0005_0001, rd);
  endtask

  task automatic t_route;
    logic [7:0] code [16] = '{8'h00, 8'h80, 8'h01, 8'h02, 8'h41, 8'h42, 8'h43, 8'h44,
                              8'h45, 8'h46, 8'h47, 8'hc1, 8'hc5, 8'hc7, 8'h81, 8'h05};
    logic want [16] = '{0, 1, 1, 0, 1, 0, 0, 0, 1, 0, 1, 0, 0, 0, 0, 1};
    set(`DIO_MAPEN_OFS, 32'h1);
    settle();
    look(32'h11, 32'h0011_0001);
    for (int i = 0; i < 16; i++)
    begin
      set(8'h88, 32'(code[i]));
      settle();
      chk("routed home bit", 32'h0011_0001 | (32'(want[i]) << 2), inputImage);
    end
    set(8'hc0, 32'h0);
    settle();
    chk("routed level bit", 32'h0010_0005, inputImage);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_levels();
    t_invert();
    t_force();
    t_pairs();
    t_freeze();
    t_outputs();
    t_route();
    report_and_stop();
  end
endmodule // test_digital_input_conditioning_router
